/* design/scr_cmd_access.sv */
// Serial command front end: takes the command byte from the serial pins and
// runs the register data phase that follows it.
// Assumes the serial pins are asynchronous to I_SYS_CLK and that the serial
// clock is slow enough (at most a fifth of I_SYS_CLK) for two-flop sampling.
`timescale 1ns/10ps
`default_nettype none

module scr_cmd_access
   import scr_pkg::*;
#(
   parameter logic [15:0] GAIN_DEFAULT = GAIN_NOMINAL
) (
   input wire logic I_SYS_CLK,
   input wire logic I_RESET_N,
   input wire logic I_SCLK,
   input wire logic I_CS_N,
   input wire logic I_SDI,
   input wire logic [7:0] I_FIFO_FLAGS,
   input wire logic [15:0] I_FIFO_WORD,
   output logic O_SDO,
   output logic O_SDO_OE,
   output logic [7:0] O_CMD_BYTE,
   output logic [23:0] O_FIFO_THRESHOLD,
   output logic O_FIFO_WORD_RD
);

   // ----------------------------------------------------------------------
   // Pin synchronisers and edge detection
   // ----------------------------------------------------------------------
   logic [2:0] sclk_s_r;
   logic [1:0] cs_s_r;
   logic [1:0] sdi_s_r;

   // Only the second and third stages feed logic.
   always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         sclk_s_r <= 3'h7;
         cs_s_r <= 2'h3;
         sdi_s_r <= 2'h0;
      end else begin
         sclk_s_r <= {sclk_s_r[1:0], I_SCLK};
         cs_s_r <= {cs_s_r[0], I_CS_N};
         sdi_s_r <= {sdi_s_r[0], I_SDI};
      end
   end

   wire sclk_rise = sclk_s_r[1] & ~sclk_s_r[2];
   wire sclk_fall = ~sclk_s_r[1] & sclk_s_r[2];
   wire cs_idle = cs_s_r[1];
   wire sdi_q = sdi_s_r[1];

   // ----------------------------------------------------------------------
   // State
   // ----------------------------------------------------------------------
   scr_state_e st_r;
   logic [4:0] cnt_r;
   logic [6:0] cmd_sh_r;
   logic [7:0] cmd_r;
   logic [23:0] rx_r;
   logic [23:0] tx_r;
   logic [1:0] ld_r;
   logic [23:0] thr_r;
   logic sdo_r;
   logic oe_r;
   logic port_rd_r;
   logic mem_we_r;
   logic [MEM_AW-1:0] mem_waddr_r;
   logic [MEM_DW-1:0] mem_wdata_r;

   scr_rf_if #(.AW(MEM_AW), .DW(MEM_DW)) rf ();

   scr_regmem #(.GAIN_DEFAULT(GAIN_DEFAULT)) u_mem (
      .i_clk(I_SYS_CLK),
      .i_rst_n(I_RESET_N),
      .rf(rf.mem)
   );

   // ----------------------------------------------------------------------
   // Command decode
   // ----------------------------------------------------------------------
   // The last command steers the data phase: address and direction.
   wire [5:0] sel = cmd_r[5:0];
   wire in_ch = (sel >= CH_FIRST) && (sel <= CH_LAST);
   wire in_gain = (sel >= GAIN_FIRST) && (sel <= GAIN_LAST);
   wire [5:0] idx = in_ch ? (sel - CH_FIRST) : (sel - GAIN_FIRST + GAIN_BASE);
   wire [7:0] cmd_full = {cmd_sh_r, sdi_q};
   wire cmd_gate_hold = (cnt_r == 5'h0) && sdi_q;
   wire cmd_done = (st_r == ST_CMD) && !cmd_gate_hold && (cnt_r[2:0] == CMD_LAST_BIT);
   wire start_rd = sclk_rise && cmd_done && cmd_full[DIR_BIT];

   // Data width of the addressed register; unmapped addresses move a byte.
   logic [4:0] dw;
   always_comb begin
      if (in_ch || (sel == FIFO_THR_ADDR)) begin
         dw = W24;
      end else if (in_gain || (sel == FIFO_PORT_ADDR)) begin
         dw = W16;
      end else begin
         dw = W8;
      end
   end

   wire last_bit = (cnt_r == (dw - 5'h1));
   wire [23:0] wdata = {rx_r[22:0], sdi_q};
   wire wr_done = sclk_rise && (st_r == ST_WR) && last_bit;

   // Read selection; read-only words are never written.
   logic [23:0] rd_val;
   always_comb begin
      if (in_ch) begin
         rd_val = rf.rdata;
      end else if (in_gain) begin
         rd_val = {8'h00, rf.rdata[15:0]};
      end else if (sel == FIFO_FLAGS_ADDR) begin
         rd_val = {16'h0000, I_FIFO_FLAGS};
      end else if (sel == FIFO_THR_ADDR) begin
         rd_val = thr_r;
      end else if (sel == FIFO_PORT_ADDR) begin
         rd_val = {8'h00, I_FIFO_WORD};
      end else begin
         rd_val = 24'h000000;
      end
   end

   // Left-align so the MSB always leaves from bit 23.
   wire [23:0] tx_load = (dw == W24) ? rd_val :
      (dw == W16) ? {rd_val[15:0], 8'h00} : {rd_val[7:0], 16'h0000};

   // ----------------------------------------------------------------------
   // Serial sequencer
   // ----------------------------------------------------------------------
   // Deasserting chip select aborts any phase and waits for a fresh command.
   always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         st_r <= ST_CMD;
         cnt_r <= 5'h0;
         cmd_sh_r <= 7'h00;
         cmd_r <= CMD_RESET;
         rx_r <= 24'h000000;
      end else if (cs_idle) begin
         st_r <= ST_CMD;
         cnt_r <= 5'h0;
      end else if (sclk_rise) begin
         case (st_r)
            ST_CMD: begin
               if (cmd_done) begin
                  cmd_r <= cmd_full;
                  cnt_r <= 5'h0;
                  rx_r <= 24'h000000;
                  st_r <= cmd_full[DIR_BIT] ? ST_RD : ST_WR;
               end else if (!cmd_gate_hold) begin
                  cmd_sh_r <= cmd_full[6:0];
                  cnt_r <= cnt_r + 5'h1;
               end
            end
            ST_WR: begin
               rx_r <= wdata;
               cnt_r <= last_bit ? 5'h0 : cnt_r + 5'h1;
               if (last_bit) begin
                  st_r <= ST_CMD;
               end
            end
            default: begin
               cnt_r <= last_bit ? 5'h0 : cnt_r + 5'h1;
               if (last_bit) begin
                  st_r <= ST_CMD;
               end
            end
         endcase
      end
   end

   // Write commit into the store or the threshold word.
   always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         mem_we_r <= 1'b0;
         mem_waddr_r <= '0;
         mem_wdata_r <= '0;
         thr_r <= FIFO_THR_RESET;
      end else begin
         mem_we_r <= wr_done && (in_ch || in_gain) && !cs_idle;
         mem_waddr_r <= idx[MEM_AW-1:0];
         mem_wdata_r <= in_gain ? {8'h00, wdata[15:0]} : wdata;
         if (wr_done && !cs_idle && (sel == FIFO_THR_ADDR)) begin
            thr_r <= wdata;
         end
      end
   end

   // Read path: two cycles to fetch, then shift out on falling serial edges.
   // The host samples on rising edges, so the MSB is ready before the first.
   always_ff @(posedge I_SYS_CLK or negedge I_RESET_N) begin
      if (!I_RESET_N) begin
         ld_r <= 2'h0;
         tx_r <= 24'h000000;
         sdo_r <= 1'b0;
         oe_r <= 1'b0;
         port_rd_r <= 1'b0;
      end else begin
         ld_r <= cs_idle ? 2'h0 : {ld_r[0], start_rd};
         port_rd_r <= ld_r[1] && !cs_idle && (sel == FIFO_PORT_ADDR);
         if (ld_r[1]) begin
            tx_r <= tx_load;
         end else if (sclk_fall && (st_r == ST_RD)) begin
            sdo_r <= tx_r[23];
            tx_r <= {tx_r[22:0], 1'b0};
         end
         if (cs_idle || (sclk_rise && (st_r == ST_RD) && last_bit)) begin
            oe_r <= 1'b0;
         end else if (start_rd) begin
            oe_r <= 1'b1;
         end
      end
   end

   assign rf.we = mem_we_r;
   assign rf.waddr = mem_waddr_r;
   assign rf.wdata = mem_wdata_r;
   assign rf.raddr = idx[MEM_AW-1:0];

   // ----------------------------------------------------------------------
   // Outputs, all from flops
   // ----------------------------------------------------------------------
   assign O_SDO = sdo_r;
   assign O_SDO_OE = oe_r;
   assign O_CMD_BYTE = cmd_r;
   assign O_FIFO_THRESHOLD = thr_r;
   assign O_FIFO_WORD_RD = port_rd_r;

endmodule

`default_nettype wire

/* inc/scr_pkg.sv */
// Constants for the serial command front end: command layout, register map,
// register widths and reset values.
// Assumes one system clock; the front end synchronises the serial pins itself.
//
// How it works
// - A 1 in command bit 7 is ignored; the front end waits for a 0.
// - After the 0 gate bit, the next seven bits complete the command byte.
// - Command bit 6 picks write (0) or read (1) for the data phase.
// - Command bits 5 to 0 select which register the data phase reaches.
// - The command register has no address and resets to 0x10.
// - Channel configuration 0 resets to 0x800100, all others to 0x000100.
// - Gain coefficients reset to the calibrated coefficient, nominally 0x5555.
`default_nettype none

package scr_pkg;

   // ----------------------------------------------------------------------
   // Command byte layout
   // ----------------------------------------------------------------------
   localparam int unsigned GATE_BIT = 7;
   localparam int unsigned DIR_BIT = 6;
   localparam logic [7:0] CMD_RESET = 8'h10;
   localparam logic [2:0] CMD_LAST_BIT = 3'h7;

   // ----------------------------------------------------------------------
   // Register map
   // ----------------------------------------------------------------------
   localparam logic [5:0] CH_FIRST = 6'h09;
   localparam logic [5:0] CH_LAST = 6'h18;
   localparam logic [5:0] GAIN_FIRST = 6'h31;
   localparam logic [5:0] GAIN_LAST = 6'h38;
   localparam logic [5:0] FIFO_FLAGS_ADDR = 6'h3b;
   localparam logic [5:0] FIFO_THR_ADDR = 6'h3c;
   localparam logic [5:0] FIFO_PORT_ADDR = 6'h3d;

   // ----------------------------------------------------------------------
   // Storage layout, widths and reset values
   // ----------------------------------------------------------------------
   localparam int unsigned NUM_CH = 16;
   localparam int unsigned NUM_GAIN = 8;
   localparam logic [5:0] GAIN_BASE = 6'h10;
   localparam int unsigned MEM_AW = 5;
   localparam int unsigned MEM_DW = 24;
   localparam logic [4:0] W24 = 5'h18;
   localparam logic [4:0] W16 = 5'h10;
   localparam logic [4:0] W8 = 5'h08;
   localparam logic [23:0] CH0_RESET = 24'h800100;
   localparam logic [23:0] CHN_RESET = 24'h000100;
   localparam logic [15:0] GAIN_NOMINAL = 16'h5555;
   localparam logic [23:0] FIFO_THR_RESET = 24'hfff000;

   typedef enum logic [1:0] {
      ST_CMD,
      ST_WR,
      ST_RD
   } scr_state_e;

endpackage

`default_nettype wire

/* inc/scr_rf_if.sv */
// Write and read port between the command front end and its register store.
// Assumes both ends run on the same system clock.
`timescale 1ns/10ps
`default_nettype none

interface scr_rf_if #(
   parameter int unsigned AW = 5,
   parameter int unsigned DW = 24
);
   logic we;
   logic [AW-1:0] waddr;
   logic [DW-1:0] wdata;
   logic [AW-1:0] raddr;
   logic [DW-1:0] rdata;

   modport ctl (output we, output waddr, output wdata, output raddr, input rdata);
   modport mem (input we, input waddr, input wdata, input raddr, output rdata);
endinterface

`default_nettype wire

/* design/scr_regmem.sv */
// Register store for the channel configuration and gain coefficient words.
// Assumes one write per cycle at most; read data come out one cycle late.
`timescale 1ns/10ps
`default_nettype none

module scr_regmem
   import scr_pkg::*;
#(
   parameter int unsigned DEPTH = NUM_CH + NUM_GAIN,
   parameter logic [15:0] GAIN_DEFAULT = GAIN_NOMINAL
) (
   input wire logic i_clk,
   input wire logic i_rst_n,
   scr_rf_if.mem rf
);

   logic [MEM_DW-1:0] ent_r [DEPTH];
   logic [MEM_DW-1:0] rdata_r;

   // ----------------------------------------------------------------------
   // Entries with their own reset values
   // ----------------------------------------------------------------------
   // Each entry is a flop word so that reset defaults appear without a load phase.
   for (genvar i = 0; i < DEPTH; i++) begin : g_ent
      localparam logic [MEM_DW-1:0] RST = (i == 0) ? CH0_RESET :
         (i < NUM_CH) ? CHN_RESET : {8'h00, GAIN_DEFAULT};
      always_ff @(posedge i_clk or negedge i_rst_n) begin
         if (!i_rst_n) begin
            ent_r[i] <= RST;
         end else if (rf.we && (rf.waddr == MEM_AW'(i))) begin
            ent_r[i] <= rf.wdata;
         end
      end
   end

   // Registered read port.
   always_ff @(posedge i_clk or negedge i_rst_n) begin
      if (!i_rst_n) begin
         rdata_r <= '0;
      end else begin
         rdata_r <= ent_r[rf.raddr];
      end
   end

   assign rf.rdata = rdata_r;

endmodule

`default_nettype wire

/* sim/scr_cmd_access_properties.sv */
// Concurrent checks on the serial command front end, bound to its top module.
// Assumes only the top module's ports are visible and one system clock.
`timescale 1ns/10ps
`default_nettype none

module scr_cmd_access_properties
   import scr_pkg::*;
(
   input wire logic I_SYS_CLK,
   input wire logic I_RESET_N,
   input wire logic I_SCLK,
   input wire logic I_CS_N,
   input wire logic O_SDO,
   input wire logic O_SDO_OE,
   input wire logic [7:0] O_CMD_BYTE,
   input wire logic [23:0] O_FIFO_THRESHOLD,
   input wire logic O_FIFO_WORD_RD
);
   // Every check runs on the system clock and sleeps during reset.
   default clocking cb @(posedge I_SYS_CLK); endclocking
   default disable iff (!I_RESET_N);

   property p_cmd_reset;
      $rose(I_RESET_N) |-> O_CMD_BYTE == CMD_RESET;
   endproperty
   a_cmd_reset: assert property (p_cmd_reset) else $error("command reset value wrong");
   property p_out_reset;
      $rose(I_RESET_N) |-> O_FIFO_THRESHOLD == FIFO_THR_RESET && !O_SDO_OE && !O_FIFO_WORD_RD
         && O_CMD_BYTE == CMD_RESET;
   endproperty
   a_out_reset: assert property (p_out_reset) else $error("output reset values wrong");
   property p_gate_zero;
      $changed(O_CMD_BYTE) |-> !O_CMD_BYTE[GATE_BIT];
   endproperty
   a_gate_zero: assert property (p_gate_zero) else $error("command taken with gate set");
   property p_oe_read;
      O_SDO_OE |-> O_CMD_BYTE[DIR_BIT];
   endproperty
   a_oe_read: assert property (p_oe_read) else $error("output driven on a write");
   property p_thr_addr;
      $changed(O_FIFO_THRESHOLD) |-> O_CMD_BYTE == {2'b00, FIFO_THR_ADDR};
   endproperty
   a_thr_addr: assert property (p_thr_addr) else $error("threshold written by other command");
   property p_word_rd;
      O_FIFO_WORD_RD |-> O_SDO_OE && O_CMD_BYTE == {2'b01, FIFO_PORT_ADDR} ##1 !O_FIFO_WORD_RD;
   endproperty
   a_word_rd: assert property (p_word_rd) else $error("fifo word pulse wrong");
   // Eight idle cycles cover the two-flop sync and the output register.
   property p_cs_idle;
      I_CS_N [*8] |-> !O_SDO_OE;
   endproperty
   a_cs_idle: assert property (p_cs_idle) else $error("output driven while deselected");
   property p_sdo_fall;
      O_SDO_OE && $past(O_SDO_OE) && $changed(O_SDO) |-> !$past(I_SCLK, 3);
   endproperty
   a_sdo_fall: assert property (p_sdo_fall) else $error("read bit moved off a falling edge");
endmodule

bind scr_cmd_access scr_cmd_access_properties u_props (.I_SYS_CLK(I_SYS_CLK),
   .I_RESET_N(I_RESET_N), .I_SCLK(I_SCLK), .I_CS_N(I_CS_N), .O_SDO(O_SDO),
   .O_SDO_OE(O_SDO_OE), .O_CMD_BYTE(O_CMD_BYTE), .O_FIFO_THRESHOLD(O_FIFO_THRESHOLD),
   .O_FIFO_WORD_RD(O_FIFO_WORD_RD));

`default_nettype wire

/* sim/scr_host_model.sv */
// Host controller model that drives the serial pins in mode 3.
// Assumes its clock is the device system clock; it changes pins on falling edges.
`timescale 1ns/10ps
`default_nettype none

module scr_host_model (
   input wire logic i_clk,
   input wire logic i_sdo,
   output logic o_sclk,
   output logic o_cs_n,
   output logic o_sdi
);
   // The serial clock idles high and stands still between frames.
   initial begin
      o_sclk = 1'b1;
      o_cs_n = 1'b1;
      o_sdi = 1'b0;
   end

   // Half periods of six cycles keep clear of the five-cycle sync limit.
   task automatic hold(input int n);
      repeat (n) @(negedge i_clk);
   endtask

   // Shifts the low n bits of v MSB first, command byte leading.
   task automatic frame(input logic [39:0] v, input int n, output logic [39:0] rd);
      rd = '0;
      o_cs_n = 1'b0;
      hold(4);
      for (int i = n - 1; i >= 0; i--) begin
         o_sclk = 1'b0;
         o_sdi = v[i]; // Gate, direction, select, then data.
         hold(6);
         o_sclk = 1'b1;
         rd = {rd[38:0], i_sdo};
         hold(6);
      end
      o_sdi = ~o_sdi; // A stale level must never look like valid data.
      hold(4);
      o_cs_n = 1'b1;
      hold(6);
   endtask
endmodule

`default_nettype wire

/* sim/scr_cmd_access_tb.sv */
// Self-checking bench for the serial command front end.
// Assumes the host model and the bound checker; random data from a fixed seed.
`timescale 1ns/10ps
`default_nettype none

module scr_cmd_access_tb;
   import scr_pkg::*;
   logic clk, rst_n, sclk, cs_n, sdi, sdo, sdo_oe, word_rd, sdo_line;
   logic [7:0] flags, cmd_byte;
   logic [15:0] word;
   logic [23:0] thr, d, q;
   logic [39:0] rd;
   logic [31:0] r;
   logic [5:0] a;
   int n_errors = 0, n_checks = 0, seed = 32'h15d2, n_word_rd = 0;

   scr_cmd_access u_dut (.I_SYS_CLK(clk), .I_RESET_N(rst_n), .I_SCLK(sclk), .I_CS_N(cs_n),
      .I_SDI(sdi), .I_FIFO_FLAGS(flags), .I_FIFO_WORD(word), .O_SDO(sdo),
      .O_SDO_OE(sdo_oe), .O_CMD_BYTE(cmd_byte), .O_FIFO_THRESHOLD(thr),
      .O_FIFO_WORD_RD(word_rd));
   scr_host_model u_host (.i_clk(clk), .i_sdo(sdo_line), .o_sclk(sclk), .o_cs_n(cs_n),
      .o_sdi(sdi));

   // A released data line shows the inverse of its last level, so a read bit
   // taken while the output is off can never match by luck.
   assign sdo_line = sdo_oe ? sdo : ~sdo;
   // Count fifo word pulses mid-cycle, where the flop output has settled.
   always @(negedge clk) begin
      if (word_rd) begin
         n_word_rd++;
      end
   end

   // Data width of each address, and its value mask.
   function automatic logic [23:0] msk(input logic [5:0] x);
      if ((x >= CH_FIRST && x <= CH_LAST) || x == FIFO_THR_ADDR) return 24'hffffff;
      if ((x >= GAIN_FIRST && x <= GAIN_LAST) || x == FIFO_PORT_ADDR) return 24'h00ffff;
      return 24'h0000ff;
   endfunction
   // Reset value of a stored word; the gap between the two banks reads 0.
   function automatic logic [23:0] rst_val(input logic [5:0] x);
      if (x == CH_FIRST) return CH0_RESET;
      if (x <= CH_LAST) return CHN_RESET;
      if (x >= GAIN_FIRST) return {8'h00, GAIN_NOMINAL};
      return 24'h000000;
   endfunction

   task automatic check(input string what, input logic [23:0] seen, input logic [23:0] exp);
      n_checks++;
      if (seen !== exp) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", what, exp, seen);
      end
   endtask
   // One whole transaction: command byte, then as many bits as the register is wide.
   task automatic acc(input logic [7:0] cmd, input logic [23:0] dv, output logic [23:0] qv);
      int w;
      w = $countones(msk(cmd[5:0]));
      u_host.frame((40'(cmd) << w) | 40'(dv), w + 8, rd);
      qv = rd[23:0] & msk(cmd[5:0]);
   endtask
   task automatic print_verdict();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) begin
         $display("Testbench passed");
      end else begin
         $display("Testbench failed");
      end
      $finish;
   endtask

   // Free-running 50 MHz clock.
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // A hang anywhere counts as a failure.
   initial begin
      repeat (100000) @(posedge clk);
      n_errors++;
      print_verdict();
   end
   // Main sequence: reset values, random write and read-back, gate, abort, fifo reads.
   initial begin
      rst_n = 1'b0;
      flags = 8'h00;
      word = 16'h0000;
      repeat (6) @(negedge clk);
      check("cmd_rst", 24'(cmd_byte), 24'(CMD_RESET));
      rst_n = 1'b1;
      repeat (4) @(negedge clk);
      check("thr_rst", thr, FIFO_THR_RESET);
      for (int x = CH_FIRST; x <= GAIN_LAST; x++) begin
         acc({2'b01, 6'(x)}, 24'h0, q);
         check("rst_val", q, rst_val(6'(x)));
      end
      for (int k = 0; k < 12; k++) begin
         r = $random(seed);
         a = (k % 3 == 0) ? CH_FIRST + 6'(r[3:0]) : (k % 3 == 1) ? GAIN_FIRST + 6'(r[2:0])
            : FIFO_THR_ADDR;
         d = ((k < 3) ? 24'hffffff : r[31:8]) & msk(a);
         acc({2'b00, a}, d, q);
         check("cmd", 24'(cmd_byte), 24'({2'b00, a}));
         if (a == FIFO_THR_ADDR) check("thr", thr, d);
         acc({2'b01, a}, 24'h0, q);
         check("rdback", q, d);
      end
      u_host.frame({5'h0, 3'b111, 8'h3c, 24'h5a5a5a}, 35, rd);
      check("gate", thr, 24'h5a5a5a);
      u_host.frame({16'h0, 8'h3c, 16'h1234}, 24, rd);
      check("abort", thr, 24'h5a5a5a);
      // A read cut after eight data bits: the top byte arrives, then the output lets go.
      u_host.frame({24'h0, 8'h7c, 8'h00}, 16, rd);
      check("rd_abort", 24'(rd[7:0]), 24'h00005a);
      check("oe_abort", 24'(sdo_oe), 24'h000000);
      acc(8'h19, 24'hff, q);
      acc(8'h59, 24'h0, q);
      check("unmapped", q, 24'h0);
      r = $random(seed);
      flags = r[7:0];
      word = r[31:16];
      acc(8'h7b, 24'h0, q);
      check("flags", q, 24'(flags));
      acc(8'h7d, 24'h0, q);
      check("word", q, 24'(word));
      check("word_rd", 24'(n_word_rd), 24'h000001);
      print_verdict();
   end
endmodule

`default_nettype wire
